// ==== src/msh_pkg.sv ====
// package: constants and carriers for the motion sequence and homing control
package msh_pkg;

  // =====================================================
  // widths
  localparam int POS_W = 32;
  localparam int METHOD_W = 4;
  localparam int EDGE_W = 3;

  // =====================================================
  // homing method codes (lowest digit of the method setting)
  localparam logic [METHOD_W-1:0] METHOD_HERE = 4'h0;
  localparam logic [METHOD_W-1:0] METHOD_NEG_LIMIT = 4'h1;
  localparam logic [METHOD_W-1:0] METHOD_POS_LIMIT = 4'h2;
  localparam logic [METHOD_W-1:0] METHOD_HOME_POS_A = 4'h3;
  localparam logic [METHOD_W-1:0] METHOD_HOME_NEG_A = 4'h4;
  localparam logic [METHOD_W-1:0] METHOD_HOME_POS_B = 4'h5;
  localparam logic [METHOD_W-1:0] METHOD_HOME_NEG_B = 4'h6;

  // =====================================================
  // step change edge settings
  localparam logic [EDGE_W-1:0] STEP_RISE = 3'h0;
  localparam logic [EDGE_W-1:0] STEP_FALL = 3'h1;
  localparam logic [EDGE_W-1:0] STEP_BOTH = 3'h2;
  localparam logic [EDGE_W-1:0] STEP_HIGH = 3'h3;
  localparam logic [EDGE_W-1:0] STEP_LOW = 3'h4;

  // =====================================================
  // reset values
  localparam logic [POS_W-1:0] ZERO_RESET = 32'h0000_0000;
  localparam logic DIR_POS = 1'b1;
  localparam logic DIR_NEG = 1'b0;

  // =====================================================
  // homing states
  typedef enum logic [2:0] {
    HS_IDLE = 3'b001,
    HS_SEARCH = 3'b010,
    HS_INDEX = 3'b100
  } msh_home_state_t;

  // =====================================================
  // carriers
  typedef struct packed {
    logic seqRun;
    logic stepIn;
    logic homeSwitch;
    logic homeTrigger;
    logic limitPos;
    logic limitNeg;
    logic encIndex;
    logic alarmClear;
  } msh_in_t;

  typedef struct packed {
    logic [METHOD_W-1:0] homeMethod;
    logic [EDGE_W-1:0] stepEdge;
  } msh_cfg_t;

  typedef struct packed {
    logic motionEnable;
    logic restartLoad;
    logic stepAdvance;
    logic homingBusy;
    logic searchMove;
    logic searchDir;
    logic homeDone;
    logic [POS_W-1:0] zeroPos;
    logic [POS_W-1:0] absTarget;
  } msh_out_t;

endpackage : msh_pkg

// ==== src/msh_ctrl.sv ====
// module: motion sequence run gating, step change and homing control
// What this block does
// - run input allows motion, dropping it pauses
// - method 0 takes present position as zero
// - homing trigger starts selected zero search
// - homing only while run input active
// - absolute targets referenced to located zero
// - step advance on rise, fall or both edges, or at high or low level
`timescale 1ns/100ps
module msh_ctrl (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire msh_pkg::msh_in_t ctrlIn,
  input wire msh_pkg::msh_cfg_t cfgIn,
  input wire logic [msh_pkg::POS_W-1:0] curPos,
  input wire logic [msh_pkg::POS_W-1:0] seqTarget,
  output msh_pkg::msh_out_t ctrlOut
);
  import msh_pkg::*;

  // =====================================================
  // edge helpers
  function automatic logic rising(input logic prev, input logic cur);
    rising = cur & ~prev;
  endfunction : rising

  function automatic logic falling(input logic prev, input logic cur);
    falling = prev & ~cur;
  endfunction : falling

  // =====================================================
  // state
  msh_in_t prevIn;
  logic motionEnable;
  logic restartLoad;
  logic stepAdvance;
  msh_home_state_t homeState;
  logic homingBusy;
  logic searchMove;
  logic searchDir;
  logic homeDone;
  logic [POS_W-1:0] zeroPos;
  logic [POS_W-1:0] absTarget;

  msh_in_t next_prevIn;
  logic next_motionEnable;
  logic next_restartLoad;
  logic next_stepAdvance;
  msh_home_state_t next_homeState;
  logic next_homingBusy;
  logic next_searchMove;
  logic next_searchDir;
  logic next_homeDone;
  logic [POS_W-1:0] next_zeroPos;
  logic [POS_W-1:0] next_absTarget;

  logic homeAccept;

  logic searchHit;
  logic searchDirSel;
  logic methodValid;

  // =====================================================
  // method decode
  always_comb begin
    searchHit = 1'b0;
    searchDirSel = DIR_POS;
    methodValid = 1'b1;
    unique case (cfgIn.homeMethod)
      METHOD_HERE: begin
        searchHit = 1'b1;
      end
      METHOD_NEG_LIMIT: begin
        searchHit = ctrlIn.limitNeg;
        searchDirSel = DIR_NEG;
      end
      METHOD_POS_LIMIT: begin
        searchHit = ctrlIn.limitPos;
        searchDirSel = DIR_POS;
      end
      METHOD_HOME_POS_A, METHOD_HOME_POS_B: begin
        searchHit = ctrlIn.homeSwitch;
        searchDirSel = DIR_POS;
      end
      METHOD_HOME_NEG_A, METHOD_HOME_NEG_B: begin
        searchHit = ctrlIn.homeSwitch;
        searchDirSel = DIR_NEG;
      end
      default: begin
        methodValid = 1'b0;
      end
    endcase
  end

  // =====================================================
  // run gating and restart
  always_comb begin
    next_prevIn = ctrlIn;
    next_motionEnable = motionEnable;
    next_restartLoad = 1'b0;
    if (!ctrlIn.seqRun || ctrlIn.alarmClear) begin
      next_motionEnable = 1'b0;
    end else if (rising(prevIn.seqRun, ctrlIn.seqRun)) begin
      next_motionEnable = 1'b1;
      next_restartLoad = 1'b1;
    end
  end

  // run group registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prevIn <= '0;
      motionEnable <= 1'b0;
      restartLoad <= 1'b0;
    end else begin
      prevIn <= next_prevIn;
      motionEnable <= next_motionEnable;
      restartLoad <= next_restartLoad;
    end
  end

  // =====================================================
  // step change
  always_comb begin
    next_stepAdvance = 1'b0;
    if (next_motionEnable) begin
      unique case (cfgIn.stepEdge)
        STEP_RISE: next_stepAdvance = rising(prevIn.stepIn, ctrlIn.stepIn);
        STEP_FALL: next_stepAdvance = falling(prevIn.stepIn, ctrlIn.stepIn);
        STEP_BOTH: next_stepAdvance = prevIn.stepIn ^ ctrlIn.stepIn;
        STEP_HIGH: next_stepAdvance = ctrlIn.stepIn;
        STEP_LOW: next_stepAdvance = ~ctrlIn.stepIn;
        default: next_stepAdvance = 1'b0;
      endcase
    end
  end

  // step group registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      stepAdvance <= 1'b0;
    end else begin
      stepAdvance <= next_stepAdvance;
    end
  end

  // =====================================================
  // homing
  always_comb begin
    next_homeState = homeState;
    next_homingBusy = homingBusy;
    next_searchMove = searchMove;
    next_searchDir = searchDir;
    next_homeDone = homeDone;
    next_zeroPos = zeroPos;
    homeAccept = rising(prevIn.homeTrigger, ctrlIn.homeTrigger) && ctrlIn.seqRun
        && methodValid;
    unique case (homeState)
      HS_IDLE: begin
        if (homeAccept) begin
          next_homeDone = 1'b0;
          if (cfgIn.homeMethod == METHOD_HERE) begin
            next_zeroPos = curPos;
            next_homeDone = 1'b1;
          end else begin
            next_homeState = HS_SEARCH;
            next_searchDir = searchDirSel;
            next_homingBusy = 1'b1;
            next_searchMove = 1'b1;
          end
        end
      end
      HS_SEARCH: begin
        if (searchHit) begin
          next_homeState = HS_INDEX;
        end
      end
      HS_INDEX: begin
        if (rising(prevIn.encIndex, ctrlIn.encIndex)) begin
          next_zeroPos = curPos;
          next_homeDone = 1'b1;
          next_homingBusy = 1'b0;
          next_searchMove = 1'b0;
          next_homeState = HS_IDLE;
        end
      end
      default: begin
        next_homeState = HS_IDLE;
        next_homingBusy = 1'b0;
        next_searchMove = 1'b0;
      end
    endcase
    // run low aborts, and wins over a latch in the same cycle
    if (!ctrlIn.seqRun && homeState != HS_IDLE) begin
      next_homeState = HS_IDLE;
      next_homingBusy = 1'b0;
      next_searchMove = 1'b0;
      next_homeDone = homeDone;
      next_zeroPos = zeroPos;
    end
    next_absTarget = POS_W'(seqTarget + next_zeroPos);
  end

  // homing group registers
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      homeState <= HS_IDLE;
      homingBusy <= 1'b0;
      searchMove <= 1'b0;
      searchDir <= DIR_NEG;
      homeDone <= 1'b0;
      zeroPos <= ZERO_RESET;
      absTarget <= ZERO_RESET;
    end else begin
      homeState <= next_homeState;
      homingBusy <= next_homingBusy;
      searchMove <= next_searchMove;
      searchDir <= next_searchDir;
      homeDone <= next_homeDone;
      zeroPos <= next_zeroPos;
      absTarget <= next_absTarget;
    end
  end

  // =====================================================
  // outputs, all from flops
  assign ctrlOut = '{
    motionEnable: motionEnable,
    restartLoad: restartLoad,
    stepAdvance: stepAdvance,
    homingBusy: homingBusy,
    searchMove: searchMove,
    searchDir: searchDir,
    homeDone: homeDone,
    zeroPos: zeroPos,
    absTarget: absTarget
  };

endmodule : msh_ctrl

// ==== testbench/msh_ctrl_chk.sv ====
// checker: port assertions for the motion sequence and homing control
`timescale 1ns/100ps
module msh_ctrl_chk (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire msh_pkg::msh_in_t ctrlIn,
  input wire msh_pkg::msh_cfg_t cfgIn,
  input wire logic [msh_pkg::POS_W-1:0] curPos,
  input wire logic [msh_pkg::POS_W-1:0] seqTarget,
  input wire msh_pkg::msh_out_t ctrlOut
);
  import msh_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  AST_RUN_ARM: assert property ($rose(ctrlIn.seqRun) && !ctrlIn.alarmClear |=>
    ctrlOut.motionEnable && ctrlOut.restartLoad) else $error("run rise did not arm");
  AST_RUN_DROP: assert property (!ctrlIn.seqRun |=> !ctrlOut.motionEnable)
    else $error("motion kept after run low");
  AST_HERE_ZERO: assert property ($rose(ctrlIn.homeTrigger) && ctrlIn.seqRun
    && !ctrlOut.homingBusy && cfgIn.homeMethod == METHOD_HERE
    |=> ctrlOut.homeDone && ctrlOut.zeroPos == $past(curPos)) else $error("zero not taken");
  AST_HOME_START: assert property ($rose(ctrlIn.homeTrigger) && ctrlIn.seqRun
    && !ctrlOut.homingBusy && cfgIn.homeMethod inside {[1:6]}
    |=> ctrlOut.homingBusy && ctrlOut.searchMove) else $error("search not started");
  AST_NO_RUN_HOME: assert property (!ctrlIn.seqRun |=> !ctrlOut.searchMove)
    else $error("search while run low");
  AST_ABS_REF: assert property (ctrlOut.homeDone |=>
    ctrlOut.absTarget == $past(seqTarget) + ctrlOut.zeroPos) else $error("target not offset");
  AST_STEP_EDGE: assert property (ctrlOut.motionEnable && ctrlIn.seqRun
    && !ctrlIn.alarmClear && ((cfgIn.stepEdge == STEP_RISE && $rose(ctrlIn.stepIn))
    || (cfgIn.stepEdge == STEP_FALL && $fell(ctrlIn.stepIn))
    || (cfgIn.stepEdge == STEP_BOTH && $changed(ctrlIn.stepIn)))
    |=> ctrlOut.stepAdvance) else $error("step edge missed");
  AST_INDEX_LATCH: assert property ($rose(ctrlOut.homeDone)
    && $past(ctrlOut.homingBusy) |-> ctrlOut.zeroPos == $past(curPos))
    else $error("index latch wrong");
endmodule : msh_ctrl_chk
bind msh_ctrl msh_ctrl_chk u_chk (.core_clk(core_clk), .reset_n(reset_n), .ctrlIn(ctrlIn),
  .cfgIn(cfgIn), .curPos(curPos), .seqTarget(seqTarget), .ctrlOut(ctrlOut));

// ==== testbench/msh_partner.sv ====
// partner: axis model with switches, index pulses and position
`timescale 1ns/100ps
module msh_partner (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire msh_pkg::msh_out_t ctrlOut,
  output logic limitNegHit,
  output logic limitPosHit,
  output logic homeHit,
  output logic encIndex,
  output logic [msh_pkg::POS_W-1:0] curPos
);
  import msh_pkg::*;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      curPos <= 32'h0000_0105;
    end else if (ctrlOut.searchMove) begin
      curPos <= curPos + 32'h0000_0001;
    end
  end
  // each limit answers only on its own travel direction
  assign limitNegHit = ctrlOut.searchMove && ctrlOut.searchDir == DIR_NEG
      && curPos[3];
  assign limitPosHit = ctrlOut.searchMove && ctrlOut.searchDir == DIR_POS
      && curPos[3];
  assign homeHit = ctrlOut.searchMove && curPos[2];
  assign encIndex = ctrlOut.searchMove && curPos[1:0] == 2'h3;
endmodule : msh_partner

// ==== testbench/msh_ctrl_bench.sv ====
// bench: directed scenarios for the motion sequence and homing control
`timescale 1ns/100ps
module msh_ctrl_bench;
  import msh_pkg::*;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  msh_in_t inDrv = '0;
  msh_cfg_t cfgIn = '0;
  logic [POS_W-1:0] seqTarget = 32'h0000_1000;
  logic [POS_W-1:0] curPos;
  logic limitNegHit;
  logic limitPosHit;
  logic homeHit;
  logic encIndex;
  msh_in_t ctrlIn;
  msh_out_t ctrlOut;
  int bad_count = 0;
  int check_count = 0;
  always #5 core_clk = ~core_clk;
  assign ctrlIn = '{inDrv.seqRun, inDrv.stepIn, homeHit, inDrv.homeTrigger, limitPosHit,
    limitNegHit, encIndex, inDrv.alarmClear};
  msh_ctrl DUT (.core_clk(core_clk), .reset_n(reset_n), .ctrlIn(ctrlIn), .cfgIn(cfgIn),
    .curPos(curPos), .seqTarget(seqTarget), .ctrlOut(ctrlOut));
  msh_partner axis (.core_clk(core_clk), .reset_n(reset_n), .ctrlOut(ctrlOut),
    .limitNegHit(limitNegHit), .limitPosHit(limitPosHit), .homeHit(homeHit),
    .encIndex(encIndex), .curPos(curPos));
  task chk(input string nm, input logic [POS_W-1:0] exp, input logic [POS_W-1:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task test_done;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  // drive run, step, trigger, alarm; look one cycle later
  task go(input logic [3:0] v);
    @(posedge core_clk);
    {inDrv.seqRun, inDrv.stepIn, inDrv.homeTrigger, inDrv.alarmClear} <= v;
    @(posedge core_clk);
    #1;
  endtask : go
  task t_run;
    go(4'h8);
    chk("restartLoad", 1'b1, ctrlOut.restartLoad);
    chk("motionEnable", 1'b1, ctrlOut.motionEnable);
    go(4'h0);
    chk("motionEnable", 1'b0, ctrlOut.motionEnable);
    go(4'h9);
    chk("motionEnable", 1'b0, ctrlOut.motionEnable);
    go(4'h8);
    chk("motionEnable", 1'b0, ctrlOut.motionEnable);
    go(4'h0);
    go(4'h8);
    chk("restartLoad", 1'b1, ctrlOut.restartLoad);
    go(4'h8);
    chk("restartLoad", 1'b0, ctrlOut.restartLoad);
    $display("t_run end");
  endtask : t_run
  task t_step;
    for (int m = 0; m < 5; m++) begin
      @(posedge core_clk);
      cfgIn.stepEdge <= 3'(m);
      go(4'hc);
      chk("stepAdvance", m != 1 && m != 4, ctrlOut.stepAdvance);
      go(4'h8);
      chk("stepAdvance", m != 0 && m != 3, ctrlOut.stepAdvance);
    end
    go(4'h0);
    chk("stepAdvance", 1'b0, ctrlOut.stepAdvance);
    go(4'h8);
    $display("t_step end");
  endtask : t_step
  task t_home;
    @(posedge core_clk);
    cfgIn.homeMethod <= METHOD_HERE;
    go(4'ha);
    chk("zeroPos", curPos, ctrlOut.zeroPos);
    chk("homeDone", 1'b1, ctrlOut.homeDone);
    chk("absTarget", seqTarget + curPos, ctrlOut.absTarget);
    for (int m = 1; m < 7; m++) begin
      @(posedge core_clk);
      cfgIn.homeMethod <= 4'(m);
      go(4'h8);
      go(4'ha);
      chk("homingBusy", 1'b1, ctrlOut.homingBusy);
      chk("searchDir", m == 2 || m == 3 || m == 5, ctrlOut.searchDir);
      for (int n = 0; n < 60 && ctrlOut.homeDone !== 1'b1; n++) begin
        @(posedge core_clk);
        #1;
      end
      chk("homeDone", 1'b1, ctrlOut.homeDone);
      if (ctrlOut.homeDone !== 1'b1) test_done();
      chk("zeroPos", curPos - 32'h0000_0001, ctrlOut.zeroPos);
      chk("absTarget", seqTarget + curPos - 32'h0000_0001, ctrlOut.absTarget);
    end
    go(4'h8);
    go(4'h2);
    chk("homingBusy", 1'b0, ctrlOut.homingBusy);
    chk("homeDone", 1'b1, ctrlOut.homeDone);
    go(4'h8);
    go(4'ha);
    chk("searchMove", 1'b1, ctrlOut.searchMove);
    go(4'h2);
    chk("searchMove", 1'b0, ctrlOut.searchMove);
    chk("homeDone", 1'b0, ctrlOut.homeDone);
    $display("t_home end");
  endtask : t_home
  initial begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    t_run();
    t_step();
    t_home();
    test_done();
  end
endmodule : msh_ctrl_bench
